/* File: omc_ctrl.sv */
// on-chip memory controller: data half, instruction half, APB regs
// assumes memory clocks are pins and memories answer on mem ticks
//
// Functional notes
// - data half carries 32-bit loads and stores
// - instruction half reads 64-bit fetches only
// - both halves reach memory directly with no arbitration
// - each half decodes its own 16 MB window
// - hits in either window are flagged non-cacheable
// - core clock runs N times memory clock, N 1..8 or legacy 1..4
// - newer variant may detect the clock ratio itself
// - separate 32-bit write and read data buses on data side
// - data side writes single bytes by per-byte enables
// - data side drives a 22-bit word address
// - newer variant may let the slave end each data transfer
// - each 64-bit fetch spans two memory cycles, two instructions
// - 32-bit init port, write-only legacy, read/write newer
// - separate 21-bit fetch read and init write addresses
// - at most one load or store per two memory cycles
// - at most two fetched instructions per two memory cycles
// - base and control registers load from tie inputs at power up
// - register block answers at base set by tie inputs
// - data memory filled by stores, instruction memory via registers
// - top eight address bits compared with base register
// - window decode only while control bit 0 is set
// - a pending load is served before a pending store
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module omc_ctrl
  import omc_pkg::*;
#(
  parameter bit LEGACY = 1'b0
)
(
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // tie-offs
  input wire logic [7:0] data_base_default_tie,
  input wire logic [7:0] data_control_default_tie,
  input wire logic [7:0] instr_base_default_tie,
  input wire logic [7:0] instr_control_default_tie,
  input wire logic [7:0] data_cfg_base_tie,
  input wire logic [7:0] instr_cfg_base_tie,
  // memory clocks
  input wire logic data_mem_clock,
  input wire logic instr_mem_clock,
  // processor data side
  input wire logic dproc_load_req,
  input wire logic dproc_store_req,
  input wire logic [31:0] dproc_addr,
  input wire logic [31:0] dproc_wdata,
  input wire logic [3:0] dproc_byte_en,
  output logic [31:0] dproc_rdata,
  output logic dproc_ack,
  output logic dproc_miss,
  output logic dproc_uncached,
  // data side memory
  output logic [21:0] dmem_addr,
  output logic [31:0] dmem_wdata,
  output logic [3:0] dmem_we,
  output logic dmem_en,
  input wire logic [31:0] dmem_rdata,
  input wire logic dmem_ready,
  // processor instruction side
  input wire logic ifetch_req,
  input wire logic [31:0] ifetch_addr,
  output logic [63:0] ifetch_data,
  output logic ifetch_ack,
  output logic ifetch_miss,
  output logic ifetch_uncached,
  // instruction side memory
  output logic [20:0] imem_rd_addr,
  output logic imem_rd_en,
  input wire logic [63:0] imem_rdata,
  output logic [20:0] imem_wr_addr,
  output logic [31:0] imem_wr_data,
  output logic imem_wr_sel,
  output logic imem_wr_en
);
  typedef enum logic [3:0] {
    D_IDLE = 4'h1, D_ISSUE = 4'h2, D_WAIT = 4'h4, D_GAP = 4'h8
  } omc_dstate_type;
  typedef enum logic [3:0] {
    I_IDLE = 4'h1, I_ISSUE = 4'h2, I_WAIT = 4'h4, I_GAP = 4'h8
  } omc_istate_type;

  logic [7:0] dbase_r, dctrl_r, ibase_r, ictrl_r;
  logic [21:0] init_addr_r;
  logic load_ties_r;
  logic dtick, itick;
  logic [2:0] ddet, idet, dratio, iratio;
  logic dauto, iauto, dvarlat;
  logic dhit, ihit;
  omc_dstate_type dstate_r;
  omc_istate_type istate_r;
  logic dis_load_r;
  logic [1:0] iop_r;
  logic init_busy_r, init_done_r;
  logic [31:0] init_rdata_r;
  logic acc, dsel, isel, mapped, init_acc;
  logic [31:0] rd_mux;

  // ********************************************************
  // ratio and mode selection
  // ********************************************************
  assign dauto = ~LEGACY & dctrl_r[OMC_CTRL_AUTO_BIT];
  assign iauto = ~LEGACY & ictrl_r[OMC_CTRL_AUTO_BIT];
  assign dvarlat = ~LEGACY & dctrl_r[OMC_CTRL_VARLAT_BIT];
  // legacy part clamps N to 4
  assign dratio = (LEGACY &&
    dctrl_r[OMC_CTRL_RATIO_MSB:OMC_CTRL_RATIO_LSB] > OMC_LEGACY_MAX_RATIO_M1)
    ? OMC_LEGACY_MAX_RATIO_M1
    : dctrl_r[OMC_CTRL_RATIO_MSB:OMC_CTRL_RATIO_LSB];
  assign iratio = (LEGACY &&
    ictrl_r[OMC_CTRL_RATIO_MSB:OMC_CTRL_RATIO_LSB] > OMC_LEGACY_MAX_RATIO_M1)
    ? OMC_LEGACY_MAX_RATIO_M1
    : ictrl_r[OMC_CTRL_RATIO_MSB:OMC_CTRL_RATIO_LSB];

  omc_tick u_dtick (
    .mclk(mclk),
    .rst(rst),
    .mem_clock(data_mem_clock),
    .auto_en(dauto),
    .ratio_m1(dratio),
    .tick(dtick),
    .det_ratio_m1(ddet)
  );

  omc_tick u_itick (
    .mclk(mclk),
    .rst(rst),
    .mem_clock(instr_mem_clock),
    .auto_en(iauto),
    .ratio_m1(iratio),
    .tick(itick),
    .det_ratio_m1(idet)
  );

  // ********************************************************
  // window decode
  // ********************************************************
  assign dhit = dctrl_r[OMC_CTRL_DEC_BIT] &
    (dproc_addr[31:OMC_WIN_LSB] == dbase_r);
  assign ihit = ictrl_r[OMC_CTRL_DEC_BIT] &
    (ifetch_addr[31:OMC_WIN_LSB] == ibase_r);

  // ********************************************************
  // APB decode
  // ********************************************************
  assign acc = psel & penable;
  assign dsel = paddr[OMC_SEL_MSB:OMC_SEL_LSB] == data_cfg_base_tie;
  assign isel = ~dsel &
    (paddr[OMC_SEL_MSB:OMC_SEL_LSB] == instr_cfg_base_tie);
  assign mapped = (dsel && paddr[OMC_OFS_MSB] == 1'b0) || isel;
  assign init_acc = isel &
    (paddr[OMC_OFS_MSB:OMC_OFS_LSB] == OMC_REG_INIT_DATA);

  always_comb begin
    rd_mux = 32'h0;
    if (dsel) begin
      case (paddr[OMC_OFS_MSB:OMC_OFS_LSB])
        OMC_REG_BASE: rd_mux = {24'h0, dbase_r};
        OMC_REG_CTRL: rd_mux = {21'h0, ddet, dctrl_r};
        default: rd_mux = 32'h0;
      endcase
    end else if (isel) begin
      case (paddr[OMC_OFS_MSB:OMC_OFS_LSB])
        OMC_REG_BASE: rd_mux = {24'h0, ibase_r};
        OMC_REG_CTRL: rd_mux = {21'h0, idet, ictrl_r};
        OMC_REG_INIT_ADDR: rd_mux = {10'h0, init_addr_r};
        OMC_REG_INIT_DATA: rd_mux = LEGACY ? 32'h0 : init_rdata_r;
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // answer after one wait state, init data waits for the memory except legacy reads
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (acc && !pready &&
        (!init_acc || init_done_r || (LEGACY && !pwrite))) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= (mapped && !pwrite) ? rd_mux : 32'h0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

  // ********************************************************
  // configuration registers
  // ********************************************************
  // ties are caught on the first edge after reset release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      load_ties_r <= 1'b1;
    end else begin
      load_ties_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dbase_r <= OMC_REG8_RST;
      dctrl_r <= OMC_REG8_RST;
      ibase_r <= OMC_REG8_RST;
      ictrl_r <= OMC_REG8_RST;
    end else if (load_ties_r) begin
      dbase_r <= data_base_default_tie;
      dctrl_r <= data_control_default_tie;
      ibase_r <= instr_base_default_tie;
      ictrl_r <= instr_control_default_tie;
    end else if (acc && pready && pwrite) begin
      if (dsel && paddr[OMC_OFS_MSB:OMC_OFS_LSB] == OMC_REG_BASE) begin
        dbase_r <= pwdata[7:0];
      end
      if (dsel && paddr[OMC_OFS_MSB:OMC_OFS_LSB] == OMC_REG_CTRL) begin
        dctrl_r <= pwdata[7:0];
      end
      if (isel && paddr[OMC_OFS_MSB:OMC_OFS_LSB] == OMC_REG_BASE) begin
        ibase_r <= pwdata[7:0];
      end
      if (isel && paddr[OMC_OFS_MSB:OMC_OFS_LSB] == OMC_REG_CTRL) begin
        ictrl_r <= pwdata[7:0];
      end
    end
  end

  // init address steps after each init data access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_addr_r <= OMC_INIT_ADDR_RST;
    end else if (acc && pready && isel && pwrite &&
        paddr[OMC_OFS_MSB:OMC_OFS_LSB] == OMC_REG_INIT_ADDR) begin
      init_addr_r <= pwdata[21:0];
    end else if (acc && pready && init_acc) begin
      init_addr_r <= init_addr_r + 22'h1;
    end
  end

  // ********************************************************
  // data half
  // ********************************************************
  // two memory ticks per access keeps one access per two cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dstate_r <= D_IDLE;
      dis_load_r <= 1'b0;
      dmem_addr <= 22'h0;
      dmem_wdata <= 32'h0;
      dmem_we <= 4'h0;
      dmem_en <= 1'b0;
      dproc_rdata <= 32'h0;
      dproc_ack <= 1'b0;
      dproc_miss <= 1'b0;
      dproc_uncached <= 1'b0;
    end else begin
      dproc_ack <= 1'b0;
      dproc_miss <= 1'b0;
      dproc_uncached <= 1'b0;
      case (dstate_r)
        D_IDLE: begin
          if (dproc_load_req || dproc_store_req) begin
            if (dhit) begin
              dis_load_r <= dproc_load_req;
              dstate_r <= D_ISSUE;
            end else begin
              dproc_miss <= 1'b1;
              dstate_r <= D_GAP;
            end
          end
        end
        D_ISSUE: begin
          if (dtick) begin
            dmem_en <= 1'b1;
            dmem_addr <= dproc_addr[OMC_WIN_LSB-1:OMC_DADDR_LSB];
            dmem_wdata <= dproc_wdata;
            dmem_we <= dis_load_r ? 4'h0 : dproc_byte_en;
            dstate_r <= D_WAIT;
          end
        end
        D_WAIT: begin
          if (dtick && (!dvarlat || dmem_ready)) begin
            dmem_en <= 1'b0;
            dmem_we <= 4'h0;
            if (dis_load_r) begin
              dproc_rdata <= dmem_rdata;
            end
            dproc_ack <= 1'b1;
            dproc_uncached <= 1'b1;
            dstate_r <= D_GAP;
          end
        end
        D_GAP: begin
          // lets the core drop its request before the next decode
          dstate_r <= D_IDLE;
        end
        default: begin
          dstate_r <= D_IDLE;
        end
      endcase
    end
  end

  // ********************************************************
  // instruction half
  // ********************************************************
  // iop 0 fetch, 1 init read, 2 init write; fetch has priority
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      istate_r <= I_IDLE;
      iop_r <= 2'h0;
      imem_rd_addr <= 21'h0;
      imem_rd_en <= 1'b0;
      imem_wr_addr <= 21'h0;
      imem_wr_data <= 32'h0;
      imem_wr_sel <= 1'b0;
      imem_wr_en <= 1'b0;
      ifetch_data <= 64'h0;
      ifetch_ack <= 1'b0;
      ifetch_miss <= 1'b0;
      ifetch_uncached <= 1'b0;
      init_busy_r <= 1'b0;
      init_done_r <= 1'b0;
      init_rdata_r <= 32'h0;
    end else begin
      ifetch_ack <= 1'b0;
      ifetch_miss <= 1'b0;
      ifetch_uncached <= 1'b0;
      if (!acc) begin
        init_done_r <= 1'b0;
        init_busy_r <= 1'b0;
      end
      case (istate_r)
        I_IDLE: begin
          if (ifetch_req) begin
            if (ihit) begin
              iop_r <= 2'h0;
              istate_r <= I_ISSUE;
            end else begin
              ifetch_miss <= 1'b1;
              istate_r <= I_GAP;
            end
          end else if (acc && init_acc && !init_busy_r && !init_done_r &&
              !(LEGACY && !pwrite)) begin
            iop_r <= pwrite ? 2'h2 : 2'h1;
            init_busy_r <= 1'b1;
            istate_r <= I_ISSUE;
          end
        end
        I_ISSUE: begin
          if (itick) begin
            if (iop_r == 2'h2) begin
              imem_wr_en <= 1'b1;
              imem_wr_addr <= init_addr_r[21:1];
              imem_wr_sel <= init_addr_r[0];
              imem_wr_data <= pwdata;
            end else begin
              imem_rd_en <= 1'b1;
              imem_rd_addr <= (iop_r == 2'h0)
                ? ifetch_addr[OMC_WIN_LSB-1:OMC_IADDR_LSB]
                : init_addr_r[21:1];
            end
            istate_r <= I_WAIT;
          end
        end
        I_WAIT: begin
          if (itick) begin
            imem_rd_en <= 1'b0;
            imem_wr_en <= 1'b0;
            if (iop_r == 2'h0) begin
              ifetch_data <= imem_rdata;
              ifetch_ack <= 1'b1;
              ifetch_uncached <= 1'b1;
            end else begin
              // first word is the upper half, big endian order
              init_rdata_r <= init_addr_r[0] ? imem_rdata[31:0]
                                              : imem_rdata[63:32];
              init_done_r <= 1'b1;
            end
            istate_r <= I_GAP;
          end
        end
        I_GAP: begin
          istate_r <= I_IDLE;
        end
        default: begin
          istate_r <= I_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: omc_pkg.sv */
// holds shared constants of the on-chip memory controller
// assumes a 100 MHz core clock and an APB register port
`default_nettype none
package omc_pkg;
  // ********************************************************
  // register map (word offsets inside each half's block)
  // ********************************************************
  localparam logic [1:0] OMC_REG_BASE = 2'h0;
  localparam logic [1:0] OMC_REG_CTRL = 2'h1;
  localparam logic [1:0] OMC_REG_INIT_ADDR = 2'h2;
  localparam logic [1:0] OMC_REG_INIT_DATA = 2'h3;
  localparam int OMC_SEL_LSB = 4;
  localparam int OMC_SEL_MSB = 11;
  localparam int OMC_OFS_LSB = 2;
  localparam int OMC_OFS_MSB = 3;
  // ********************************************************
  // control register fields
  // ********************************************************
  localparam int OMC_CTRL_DEC_BIT = 0;
  localparam int OMC_CTRL_RATIO_LSB = 1;
  localparam int OMC_CTRL_RATIO_MSB = 3;
  localparam int OMC_CTRL_VARLAT_BIT = 4;
  localparam int OMC_CTRL_AUTO_BIT = 5;
  localparam logic [2:0] OMC_LEGACY_MAX_RATIO_M1 = 3'h3;
  // ********************************************************
  // address fields
  // ********************************************************
  localparam int OMC_WIN_LSB = 24;
  localparam int OMC_DADDR_LSB = 2;
  localparam int OMC_IADDR_LSB = 3;
  localparam logic [21:0] OMC_INIT_ADDR_RST = 22'h000000;
  localparam logic [7:0] OMC_REG8_RST = 8'h00;
endpackage
`default_nettype wire

/* File: omc_tick.sv */
// memory clock tick generator with optional ratio detection
// assumes mem_clock is a pin from outside the core clock domain
`timescale 1ns/1ns
`default_nettype none
module omc_tick
  import omc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic mem_clock,
  input wire logic auto_en,
  input wire logic [2:0] ratio_m1,
  output logic tick,
  output logic [2:0] det_ratio_m1
);
  logic [2:0] sync_r;
  logic level_r;
  logic [2:0] div_r;
  logic [3:0] per_r;
  logic rise;

  // ********************************************************
  // pin synchroniser, change counted when stages 2 and 3 agree
  // ********************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], mem_clock};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      level_r <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      level_r <= sync_r[2];
    end
  end

  assign rise = sync_r[1] & sync_r[2] & ~level_r;

  // ********************************************************
  // period measure, core cycles between memory clock rises
  // ********************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      per_r <= 4'h0;
      det_ratio_m1 <= 3'h0;
    end else if (rise) begin
      per_r <= 4'h0;
      det_ratio_m1 <= (per_r > 4'h7) ? 3'h7 : per_r[2:0];
    end else if (per_r != 4'hF) begin
      per_r <= per_r + 4'h1;
    end
  end

  // programmed ratio: one tick every ratio_m1+1 core cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r <= 3'h0;
    end else if (div_r >= ratio_m1) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= auto_en ? rise : (div_r >= ratio_m1);
    end
  end
endmodule
`default_nettype wire

/* File: omc_chk.sv */
// concurrent checks on the memory controller's top-level ports
// assumes omc_ctrl is compiled first; attached by the bind at the foot
`timescale 1ns/1ns
`default_nettype none
module omc_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic dproc_load_req,
  input wire logic dproc_store_req,
  input wire logic [31:0] dproc_addr,
  input wire logic [31:0] dproc_wdata,
  input wire logic [3:0] dproc_byte_en,
  input wire logic dproc_ack,
  input wire logic dproc_miss,
  input wire logic dproc_uncached,
  input wire logic [21:0] dmem_addr,
  input wire logic [31:0] dmem_wdata,
  input wire logic [3:0] dmem_we,
  input wire logic dmem_en,
  input wire logic ifetch_req,
  input wire logic [31:0] ifetch_addr,
  input wire logic ifetch_ack,
  input wire logic ifetch_uncached,
  input wire logic [20:0] imem_rd_addr,
  input wire logic imem_rd_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ********************************************************
  // sequences
  // ********************************************************
  // init data waits on memory, so its answer time is open
  sequence s_apb_first;
    psel && penable && !$past(penable) && paddr[3:2] != 2'h3;
  endsequence
  sequence s_apb_wait;
    !pready ##1 pready;
  endsequence
  sequence s_no_dack;
    !dproc_ack [*2];
  endsequence
  sequence s_no_iack;
    !ifetch_ack [*2];
  endsequence
  // ********************************************************
  // assertions
  // ********************************************************
  chk_apb_answer: assert property (s_apb_first |-> s_apb_wait)
    else $error("apb answer not on second access cycle");
  chk_apb_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  chk_rdata_idle: assert property (
    !(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
  chk_miss_quiet: assert property (
    dproc_miss |-> !dmem_en && !dproc_ack)
    else $error("memory activity on a miss");
  chk_daddr_map: assert property (
    dmem_en |-> dmem_addr == dproc_addr[23:2])
    else $error("data word address wrong");
  chk_load_first: assert property (
    dmem_en && dproc_load_req |-> !dmem_we)
    else $error("store served before pending load");
  chk_store_lanes: assert property (dmem_en && !dproc_load_req &&
    dproc_store_req |-> dmem_we == dproc_byte_en && dmem_wdata == dproc_wdata)
    else $error("store lanes or data wrong");
  chk_data_rate: assert property (dproc_ack |=> s_no_dack)
    else $error("data accesses too close");
  chk_fetch_rate: assert property (ifetch_ack |=> s_no_iack)
    else $error("fetches too close");
  chk_uncached: assert property (dproc_uncached == dproc_ack &&
    ifetch_uncached == ifetch_ack)
    else $error("uncached flag not with answer");
  chk_fetch_addr: assert property (imem_rd_en && ifetch_req |->
    imem_rd_addr == ifetch_addr[23:3])
    else $error("fetch address wrong");
endmodule
bind omc_ctrl omc_chk chk (.*);
`default_nettype wire

/* File: omc_mem_model.sv */
// behavioural block RAMs on both memory sides of the controller
// assumes word addresses below 64; reads are combinational
`timescale 1ns/1ns
`default_nettype none
module omc_mem_model (
  input wire logic mclk,
  input wire logic [21:0] dmem_addr,
  input wire logic [31:0] dmem_wdata,
  input wire logic [3:0] dmem_we,
  input wire logic dmem_en,
  output logic [31:0] dmem_rdata,
  output logic dmem_ready,
  input wire logic [3:0] lat,
  input wire logic [20:0] imem_rd_addr,
  input wire logic imem_rd_en,
  output logic [63:0] imem_rdata,
  input wire logic [20:0] imem_wr_addr,
  input wire logic [31:0] imem_wr_data,
  input wire logic imem_wr_sel,
  input wire logic imem_wr_en
);
  logic [31:0] dm [64];
  logic [63:0] im [64];
  logic [3:0] cnt;
  logic [31:0] junk;
  initial begin
    cnt = 4'h0;
    junk = 32'h5A5A5A5A;
    for (int i = 0; i < 64; i++) begin
      dm[i] = 32'h0;
      im[i] = 64'h0;
    end
  end
  // ********************************************************
  // storage
  // ********************************************************
  always @(posedge mclk) begin
    junk <= ~junk;
    cnt <= dmem_en ? cnt + 4'h1 : 4'h0;
    for (int b = 0; b < 4; b++) begin
      if (dmem_en && dmem_we[b]) begin
        dm[dmem_addr[5:0]][8*b+:8] <= dmem_wdata[8*b+:8];
      end
    end
    if (imem_wr_en && imem_wr_sel) im[imem_wr_addr[5:0]][31:0] <= imem_wr_data;
    if (imem_wr_en && !imem_wr_sel) begin
      im[imem_wr_addr[5:0]][63:32] <= imem_wr_data;
    end
  end
  // slow slave: ready only after lat cycles of enable
  assign dmem_ready = cnt >= lat;
  // deselected reads show a moving pattern, not stale data
  assign dmem_rdata = dmem_en ? dm[dmem_addr[5:0]] : junk;
  assign imem_rdata = imem_rd_en ? im[imem_rd_addr[5:0]]
                                 : {junk, ~junk};
endmodule
`default_nettype wire

/* File: omc_tb.sv */
// self-checking bench for the on-chip memory controller
// assumes omc_pkg, omc_ctrl, omc_chk and omc_mem_model compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dproc_addr, dproc_wdata, dproc_rdata;
  logic [31:0] dmem_wdata, dmem_rdata, ifetch_addr, imem_wr_data, r;
  logic [7:0] data_base_default_tie, data_control_default_tie;
  logic [7:0] instr_base_default_tie, instr_control_default_tie;
  logic [7:0] data_cfg_base_tie, instr_cfg_base_tie;
  logic data_mem_clock, instr_mem_clock, dproc_load_req, dproc_store_req;
  logic [3:0] dproc_byte_en, dmem_we, lat, seen_we;
  logic dproc_ack, dproc_miss, dproc_uncached, dmem_en, dmem_ready;
  logic ifetch_req, ifetch_ack, ifetch_miss, ifetch_uncached;
  logic imem_rd_en, imem_wr_sel, imem_wr_en;
  logic [63:0] ifetch_data, imem_rdata, q;
  logic [21:0] dmem_addr;
  logic [20:0] imem_rd_addr, imem_wr_addr;
  logic [1:0] dv;
  logic [31:0] wa [4] = '{32'h10FFFFFC, 32'h11000000,
                          32'h0F000000, 32'h30000044};
  logic [3:0] wm = 4'hE;
  int n_mismatch, n_compared, cy;
  omc_ctrl dut (.*);
  omc_mem_model mem (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // memory clocks at a quarter of the core rate
  always @(posedge mclk) begin
    dv <= dv + 2'h1;
    data_mem_clock <= dv[1];
    instr_mem_clock <= dv[1];
    if (dmem_en === 1'b1) seen_we <= dmem_we;
  end
  // ********************************************************
  // access tasks
  // ********************************************************
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dacc(logic ld, logic st, logic [31:0] a, logic [31:0] d);
    @(posedge mclk);
    dproc_load_req <= ld;
    dproc_store_req <= st;
    dproc_addr <= a;
    dproc_wdata <= d;
    cy = 0;
    do begin
      @(posedge mclk);
      cy++;
    end while (dproc_ack !== 1'b1 && dproc_miss !== 1'b1);
    r = dproc_rdata;
    e = dproc_miss;
    dproc_load_req <= 1'b0;
    dproc_store_req <= 1'b0;
  endtask
  task automatic fetch(logic [31:0] a);
    @(posedge mclk);
    ifetch_req <= 1'b1;
    ifetch_addr <= a;
    do @(posedge mclk); while (ifetch_ack !== 1'b1 && ifetch_miss !== 1'b1);
    q = ifetch_data;
    e = ifetch_miss;
    ifetch_req <= 1'b0;
  endtask
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
  // ********************************************************
  // tests
  // ********************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, dv, lat, seen_we} = '0;
    {dproc_load_req, dproc_store_req, dproc_addr, dproc_wdata} = '0;
    {ifetch_req, ifetch_addr, data_mem_clock, instr_mem_clock} = '0;
    {n_mismatch, n_compared, cy} = '0;
    dproc_byte_en = 4'hF;
    data_base_default_tie = 8'h10;
    data_control_default_tie = 8'h01;
    instr_base_default_tie = 8'h20;
    instr_control_default_tie = 8'h01;
    data_cfg_base_tie = 8'h01;
    instr_cfg_base_tie = 8'h02;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'h0, 12'h010, 32'h0);
    `CHK("dbase", 8'h10, r[7:0])
    apb(1'h0, 12'h014, 32'h0);
    `CHK("dctrl", 1'b1, r[0])
    apb(1'h0, 12'h020, 32'h0);
    `CHK("ibase", 8'h20, r[7:0])
    apb(1'h0, 12'h018, 32'h0);
    `CHK("unmapped", 33'h100000000, {e, r})
    dacc(1'h0, 1'h1, 32'h10000044, 32'h11223344);
    dproc_byte_en <= 4'h2;
    dacc(1'h0, 1'h1, 32'h10000044, 32'hAABBCCDD);
    dproc_byte_en <= 4'hF;
    dacc(1'h1, 1'h1, 32'h10000044, 32'h0);
    `CHK("load_first", 36'h01122CC44, {seen_we, r})
    foreach (wa[i]) begin
      dacc(1'h1, 1'h0, wa[i], 32'h0);
      `CHK("window", wm[i], e)
    end
    apb(1'h1, 12'h014, 32'h0);
    dacc(1'h1, 1'h0, 32'h10000044, 32'h0);
    `CHK("decode_off", 1'b1, e)
    for (int n = 1; n <= 8; n++) begin
      apb(1'h1, 12'h014, {28'h0, 3'(n - 1), 1'b1});
      dacc(1'h1, 1'h0, 32'h10000044, 32'h0);
      `CHK("ratio_data", 32'h1122CC44, r)
      `CHK("ratio_time", 1'b1, cy >= n + 1 && cy <= 2 * n + 4)
    end
    lat <= 4'h9;
    apb(1'h1, 12'h014, 32'h11);
    dacc(1'h1, 1'h0, 32'h10000044, 32'h0);
    `CHK("slow_data", 32'h1122CC44, r)
    `CHK("slow_wait", 1'b1, cy > 9)
    lat <= 4'h0;
    apb(1'h1, 12'h014, 32'h21);
    repeat (4) dacc(1'h1, 1'h0, 32'h10000044, 32'h0);
    `CHK("auto_data", 32'h1122CC44, r)
    apb(1'h0, 12'h014, 32'h0);
    `CHK("auto_ratio", 3'h3, r[10:8])
    apb(1'h1, 12'h028, 32'h4);
    apb(1'h1, 12'h02C, 32'hA5A55A5A);
    apb(1'h1, 12'h02C, 32'h12345678);
    fetch(32'h20000010);
    `CHK("fetch", 64'hA5A55A5A12345678, q)
    apb(1'h1, 12'h028, 32'h4);
    apb(1'h0, 12'h02C, 32'h0);
    `CHK("init_read", 32'hA5A55A5A, r)
    fetch(32'h30000000);
    `CHK("fetch_miss", 1'b1, e)
    results();
  end
endmodule
`default_nettype wire
